// ---- fac_cfg.svh ----
// fac_cfg.svh: offsets, field positions, reset values and masks of the
// fifo/aux configuration register group.
// assumes: included by its bare name, 8-bit register port.
//
// Behaviour
// - FIFO-bound accel samples are decimated by two to the power of bits 6:4.
// - Bit 7 of decimation register picks filtered (1, reset) or unfiltered data.
// - Watermark is 13 bits: low register bits 7:0, high register bits 4:0.
// - High watermark resets to 0x02, low to 0x00; level 512; bits 7:5 reserved.
// - Stop-on-full bit set: no new samples written while the FIFO is full.
// - Time-enable bit (reset set) appends a sensortime frame after the last frame.
// - Header-enable bit (reset set) stores a header with each frame.
// - Aux-enable bit stores three-axis auxiliary data; cleared stores none.
// - Accel-enable bit stores three-axis acceleration data; cleared stores none.
// - Bits 3 and 2 enable tagging frame headers with pin one and pin two state.
// - Aux target bits 7:1 hold the 7-bit bus address; reset 0x20; bit 0 reserved.
// - Burst code 0,1,2,3 means 1,2,6,8 bytes; reset code 3.
// - Aux port bit 7 set (reset) is manual setup mode, clear is data mode.
`ifndef FAC_CFG_SVH
`define FAC_CFG_SVH

`define FAC_NUM_REGS 7
// register offsets
`define FAC_OFS_DECIM 8'h45
`define FAC_OFS_WTM_LO 8'h46
`define FAC_OFS_WTM_HI 8'h47
`define FAC_OFS_FRAME_A 8'h48
`define FAC_OFS_FRAME_B 8'h49
`define FAC_OFS_AUX_TGT 8'h4b
`define FAC_OFS_AUX_PORT 8'h4c
// reset values
`define FAC_RST_DECIM 8'h80
`define FAC_RST_WTM_LO 8'h00
`define FAC_RST_WTM_HI 8'h02
`define FAC_RST_FRAME_A 8'h02
`define FAC_RST_FRAME_B 8'h10
`define FAC_RST_AUX_TGT 8'h20
`define FAC_RST_AUX_PORT 8'h83
// writable bits; everything else is reserved
`define FAC_MSK_DECIM 8'hf0
`define FAC_MSK_WTM_LO 8'hff
`define FAC_MSK_WTM_HI 8'h1f
`define FAC_MSK_FRAME_A 8'h03
`define FAC_MSK_FRAME_B 8'h7c
`define FAC_MSK_AUX_TGT 8'hfe
`define FAC_MSK_AUX_PORT 8'h83
// field positions
`define FAC_BIT_FILT 7
`define FAC_DOWNS_MSB 6
`define FAC_DOWNS_LSB 4
`define FAC_WTM_HI_MSB 4
`define FAC_BIT_STOP_FULL 0
`define FAC_BIT_TIME_EN 1
`define FAC_BIT_ACC_EN 6
`define FAC_BIT_AUX_EN 5
`define FAC_BIT_HDR_EN 4
`define FAC_BIT_TAG_ONE 3
`define FAC_BIT_TAG_TWO 2
`define FAC_AUX_ADDR_MSB 7
`define FAC_AUX_ADDR_LSB 1
`define FAC_BIT_MANUAL 7
`define FAC_BURST_MSB 1
// frame header layout: marker in 7:5, aux 3, acc 2, tag one 1, tag two 0
`define FAC_HDR_MARK 3'h4
// burst lengths in bytes
`define FAC_BURST_B1 4'h1
`define FAC_BURST_B2 4'h2
`define FAC_BURST_B6 4'h6
`define FAC_BURST_B8 4'h8

`endif

// ---- fac_pkg.sv ----
// fac_pkg: types shared by the fifo/aux configuration modules.
// assumes: nothing beyond a SystemVerilog compiler.
`default_nettype none
package fac_pkg;
   typedef logic [7:0] fac_byte_t;
   typedef logic [47:0] fac_axes_t;
   typedef logic [12:0] fac_level_t;
   typedef logic [2:0] fac_idx_t;
   typedef enum logic [1:0] {
      fac_burst_one = 2'h0,
      fac_burst_two = 2'h1,
      fac_burst_six = 2'h2,
      fac_burst_eight = 2'h3
   } fac_burst_t;
endpackage
`default_nettype wire

// ---- fac_cfg_if.sv ----
// fac_cfg_if: configuration fields from the register group to its helpers.
// assumes: one driver (the register group), read by decimator and admitter.
`timescale 1ns/1ps
`default_nettype none
interface fac_cfg_if;
   logic [2:0] downs;
   logic use_filtered;
   logic stop_on_full;
   modport src (output downs, output use_filtered, output stop_on_full);
   modport dec (input downs, input use_filtered);
   modport adm (input stop_on_full);
endinterface
`default_nettype wire

// ---- fac_decimator.sv ----
// fac_decimator: source select and power-of-two decimation of accel samples.
// assumes: one sample per valid pulse, synchronous to ref_clk_in.
`timescale 1ns/1ps
`default_nettype none
module fac_decimator
   import fac_pkg::*;
(
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // configuration
   fac_cfg_if.dec cfg,
   // samples in
   input wire logic acc_valid_in,
   input wire fac_axes_t acc_raw_in,
   input wire fac_axes_t acc_filt_in,
   // decimated samples out
   output logic dec_valid_out,
   output fac_axes_t dec_data_out
);
   logic [6:0] phase_r;
   logic [6:0] keep_mask;
   logic [2:0] downs_r;

   // only every 2**downs-th sample survives; zero phase is the one kept
   always_comb begin
      keep_mask = 7'((8'h01 << cfg.downs) - 8'h01);
   end

   // phase restarts when the factor changes so the new rate begins cleanly
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         phase_r <= 7'h00;
         downs_r <= 3'h0;
      end else begin
         downs_r <= cfg.downs;
         if (downs_r != cfg.downs) begin
            phase_r <= 7'h00;
         end else if (acc_valid_in) begin
            phase_r <= (phase_r & keep_mask) == keep_mask ? 7'h00 : phase_r + 7'h01;
         end
      end
   end

   // registered output, filtered or raw path chosen per sample
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         dec_valid_out <= 1'b0;
         dec_data_out <= '0;
      end else begin
         dec_valid_out <= acc_valid_in && (phase_r & keep_mask) == 7'h00 &&
                          downs_r == cfg.downs;
         if (acc_valid_in) begin
            dec_data_out <= cfg.use_filtered ? acc_filt_in : acc_raw_in;
         end
      end
   end
endmodule // fac_decimator
`default_nettype wire

// ---- fac_fifo_admit.sv ----
// fac_fifo_admit: write policy of frames into a FIFO that may be full.
// assumes: fifo_full_in reflects the FIFO in the cycle of the request.
`timescale 1ns/1ps
`default_nettype none
module fac_fifo_admit
   import fac_pkg::*;
(
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // configuration
   fac_cfg_if.adm cfg,
   // frame request and FIFO state
   input wire logic frame_req_in,
   input wire logic fifo_full_in,
   // FIFO write control
   output logic fifo_wr_out,
   output logic drop_oldest_out,
   output logic frame_lost_out
);
   // stop mode refuses the frame; ring mode evicts the oldest to fit it
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         fifo_wr_out <= 1'b0;
         drop_oldest_out <= 1'b0;
         frame_lost_out <= 1'b0;
      end else begin
         fifo_wr_out <= frame_req_in && !(fifo_full_in && cfg.stop_on_full);
         drop_oldest_out <= frame_req_in && fifo_full_in && !cfg.stop_on_full;
         frame_lost_out <= frame_req_in && fifo_full_in && cfg.stop_on_full;
      end
   end
endmodule // fac_fifo_admit
`default_nettype wire

// ---- fac_config_regs.sv ----
// fac_config_regs: fifo and auxiliary-port configuration register group,
// with the frame assembly that those registers steer.
// assumes: register port strobes are single-cycle and synchronous to
// ref_clk_in; the FIFO storage and aux bus engine sit outside.
`timescale 1ns/1ps
`default_nettype none
`include "fac_cfg.svh"
module fac_config_regs
   import fac_pkg::*;
(
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // register port from the serial interface
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire fac_byte_t reg_addr_in,
   input wire fac_byte_t reg_wdata_in,
   output fac_byte_t reg_rdata_out,
   output logic reg_rvalid_out,
   // sensor sample inputs
   input wire logic acc_valid_in,
   input wire fac_axes_t acc_raw_in,
   input wire fac_axes_t acc_filt_in,
   input wire logic aux_valid_in,
   input wire fac_axes_t aux_data_in,
   input wire logic int_pin_one_in,
   input wire logic int_pin_two_in,
   // FIFO status and readout events
   input wire logic fifo_full_in,
   input wire fac_level_t fifo_level_in,
   input wire logic readout_last_in,
   // FIFO write side
   output logic fifo_wr_out,
   output logic fifo_drop_oldest_out,
   output logic fifo_frame_lost_out,
   output logic frame_has_header_out,
   output fac_byte_t frame_header_out,
   output logic frame_acc_present_out,
   output fac_axes_t frame_acc_out,
   output logic frame_aux_present_out,
   output fac_axes_t frame_aux_out,
   // FIFO level and readout
   output fac_level_t watermark_out,
   output logic watermark_hit_out,
   output logic sensortime_frame_out,
   // auxiliary port settings
   output logic [6:0] aux_target_addr_out,
   output logic [3:0] aux_burst_bytes_out,
   output logic aux_manual_mode_out
);
   fac_byte_t cfg_r [`FAC_NUM_REGS];
   logic wr_hit;
   logic rd_hit;
   fac_idx_t wr_idx;
   fac_idx_t rd_idx;
   logic dec_valid;
   fac_axes_t dec_data;
   logic frame_req_nxt;
   logic frame_req_r;
   logic acc_take;
   logic aux_take;
   logic hdr_mode;
   fac_axes_t aux_hold_r;
   fac_level_t watermark;

   fac_cfg_if cfg_bus();

   // address to register index; the hit flag covers the unmapped holes
   function automatic logic [3:0] fac_decode(input fac_byte_t addr);
      case (addr)
         `FAC_OFS_DECIM: fac_decode = {1'b1, 3'd0};
         `FAC_OFS_WTM_LO: fac_decode = {1'b1, 3'd1};
         `FAC_OFS_WTM_HI: fac_decode = {1'b1, 3'd2};
         `FAC_OFS_FRAME_A: fac_decode = {1'b1, 3'd3};
         `FAC_OFS_FRAME_B: fac_decode = {1'b1, 3'd4};
         `FAC_OFS_AUX_TGT: fac_decode = {1'b1, 3'd5};
         `FAC_OFS_AUX_PORT: fac_decode = {1'b1, 3'd6};
         default: fac_decode = 4'h0;
      endcase
   endfunction

   // reset value per register index
   function automatic fac_byte_t fac_reset_val(input int idx);
      case (idx)
         0: fac_reset_val = `FAC_RST_DECIM;
         1: fac_reset_val = `FAC_RST_WTM_LO;
         2: fac_reset_val = `FAC_RST_WTM_HI;
         3: fac_reset_val = `FAC_RST_FRAME_A;
         4: fac_reset_val = `FAC_RST_FRAME_B;
         5: fac_reset_val = `FAC_RST_AUX_TGT;
         default: fac_reset_val = `FAC_RST_AUX_PORT;
      endcase
   endfunction

   // writable bits per register index
   function automatic fac_byte_t fac_write_mask(input int idx);
      case (idx)
         0: fac_write_mask = `FAC_MSK_DECIM;
         1: fac_write_mask = `FAC_MSK_WTM_LO;
         2: fac_write_mask = `FAC_MSK_WTM_HI;
         3: fac_write_mask = `FAC_MSK_FRAME_A;
         4: fac_write_mask = `FAC_MSK_FRAME_B;
         5: fac_write_mask = `FAC_MSK_AUX_TGT;
         default: fac_write_mask = `FAC_MSK_AUX_PORT;
      endcase
   endfunction

   // burst code to byte count
   function automatic logic [3:0] fac_burst_bytes(input fac_burst_t code);
      case (code)
         fac_burst_one: fac_burst_bytes = `FAC_BURST_B1;
         fac_burst_two: fac_burst_bytes = `FAC_BURST_B2;
         fac_burst_six: fac_burst_bytes = `FAC_BURST_B6;
         fac_burst_eight: fac_burst_bytes = `FAC_BURST_B8;
         default: fac_burst_bytes = `FAC_BURST_B8;
      endcase
   endfunction

   // a tag bit is the pin level gated by its enable, same for both pins
   function automatic logic fac_tag(input logic pin, input logic enable);
      fac_tag = pin && enable;
   endfunction

   // decode of both strobes
   assign {wr_hit, wr_idx} = fac_decode(reg_addr_in);
   assign {rd_hit, rd_idx} = fac_decode(reg_addr_in);

   // one storage register per offset; reserved bits are masked at write
   // time so they can never hold anything but zero
   generate
      for (genvar gi = 0; gi < `FAC_NUM_REGS; gi++) begin : g_reg
         always_ff @(posedge ref_clk_in) begin
            if (rst_in) begin
               cfg_r[gi] <= fac_reset_val(gi);
            end else if (reg_wr_in && wr_hit && wr_idx == 3'(gi)) begin
               cfg_r[gi] <= reg_wdata_in & fac_write_mask(gi);
            end
         end
      end
   endgenerate

   // read data registered; unmapped offsets answer zero
   // rdata holds between reads so a slow master may sample it late
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         reg_rdata_out <= 8'h00;
         reg_rvalid_out <= 1'b0;
      end else begin
         reg_rvalid_out <= reg_rd_in;
         if (reg_rd_in) begin
            reg_rdata_out <= rd_hit ? cfg_r[rd_idx] : 8'h00;
         end
      end
   end

   // configuration fields handed to the helpers
   assign cfg_bus.downs = cfg_r[0][`FAC_DOWNS_MSB:`FAC_DOWNS_LSB];
   assign cfg_bus.use_filtered = cfg_r[0][`FAC_BIT_FILT];
   assign cfg_bus.stop_on_full = cfg_r[3][`FAC_BIT_STOP_FULL];

   // watermark spans two registers; the low byte alone never moves the top
   assign watermark = {cfg_r[2][`FAC_WTM_HI_MSB:0], cfg_r[1]};

   // level compare registered to keep the FIFO counter off long paths
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         watermark_out <= 13'h0000;
         watermark_hit_out <= 1'b0;
      end else begin
         watermark_out <= watermark;
         watermark_hit_out <= fifo_level_in >= watermark;
      end
   end

   // sensortime frame requested once the last data frame has been read
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         sensortime_frame_out <= 1'b0;
      end else begin
         sensortime_frame_out <= readout_last_in && cfg_r[3][`FAC_BIT_TIME_EN];
      end
   end

   // auxiliary port settings from storage; address and mode bit direct, burst code decoded to a byte count
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         aux_target_addr_out <= 7'h00;
         aux_burst_bytes_out <= 4'h0;
         aux_manual_mode_out <= 1'b0;
      end else begin
         aux_target_addr_out <= cfg_r[5][`FAC_AUX_ADDR_MSB:`FAC_AUX_ADDR_LSB];
         aux_burst_bytes_out <= fac_burst_bytes(fac_burst_t'(cfg_r[6][`FAC_BURST_MSB:0]));
         aux_manual_mode_out <= cfg_r[6][`FAC_BIT_MANUAL];
      end
   end

   // accel path: source select and decimation
   fac_decimator u_decimator (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .cfg(cfg_bus.dec),
      .acc_valid_in(acc_valid_in),
      .acc_raw_in(acc_raw_in),
      .acc_filt_in(acc_filt_in),
      .dec_valid_out(dec_valid),
      .dec_data_out(dec_data)
   );

   // a disabled source contributes nothing, not even a trigger
   assign acc_take = dec_valid && cfg_r[4][`FAC_BIT_ACC_EN];
   assign aux_take = aux_valid_in && cfg_r[4][`FAC_BIT_AUX_EN];
   assign hdr_mode = cfg_r[4][`FAC_BIT_HDR_EN];

   // latest aux sample kept so headerless frames can carry it with accel;
   // a newer sample simply overwrites, nothing tracks how old it is
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         aux_hold_r <= '0;
      end else if (aux_take) begin
         aux_hold_r <= aux_data_in;
      end
   end

   // header mode: each cycle with an arrival is one frame, shared when both sources arrive; headerless mode relies on
   // equal rates, so accel paces frames and aux only paces when alone
   always_comb begin
      if (hdr_mode) begin
         frame_req_nxt = acc_take || aux_take;
      end else if (cfg_r[4][`FAC_BIT_ACC_EN]) begin
         frame_req_nxt = acc_take;
      end else begin
         frame_req_nxt = aux_take;
      end
   end

   // frame request delayed one cycle so it reaches admission together
   // with the frame fields registered below
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         frame_req_r <= 1'b0;
      end else begin
         frame_req_r <= frame_req_nxt;
      end
   end

   // header byte; headerless frames carry zero so no stale tag leaks out
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         frame_has_header_out <= 1'b0;
         frame_header_out <= 8'h00;
      end else begin
         if (frame_req_nxt) begin
            frame_has_header_out <= hdr_mode;
            frame_header_out <= hdr_mode ? {`FAC_HDR_MARK, 1'b0, aux_take, acc_take,
               fac_tag(int_pin_one_in, cfg_r[4][`FAC_BIT_TAG_ONE]),
               fac_tag(int_pin_two_in, cfg_r[4][`FAC_BIT_TAG_TWO])} : 8'h00;
         end
      end
   end

   // accel payload; zero when the decimator offered nothing this frame
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         frame_acc_present_out <= 1'b0;
         frame_acc_out <= '0;
      end else begin
         if (frame_req_nxt) begin
            frame_acc_present_out <= acc_take;
            frame_acc_out <= acc_take ? dec_data : 48'h0;
         end
      end
   end

   // aux payload; headerless frames reuse the held sample, which is only
   // current while software keeps both sources at one rate
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         frame_aux_present_out <= 1'b0;
         frame_aux_out <= '0;
      end else begin
         if (frame_req_nxt) begin
            frame_aux_present_out <= hdr_mode ? aux_take :
                                     cfg_r[4][`FAC_BIT_AUX_EN];
            frame_aux_out <= aux_take ? aux_data_in :
                             (!hdr_mode && cfg_r[4][`FAC_BIT_AUX_EN]) ? aux_hold_r : 48'h0;
         end
      end
   end

   // FIFO admission: stop when full, or evict oldest
   fac_fifo_admit u_admit (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .cfg(cfg_bus.adm),
      .frame_req_in(frame_req_r),
      .fifo_full_in(fifo_full_in),
      .fifo_wr_out(fifo_wr_out),
      .drop_oldest_out(fifo_drop_oldest_out),
      .frame_lost_out(fifo_frame_lost_out)
   );
endmodule // fac_config_regs
`default_nettype wire

// ---- fac_config_regs_asserts.sv ----
// fac_config_regs_asserts: port-level timing checks of the register group.
// assumes: bound to fac_config_regs; one clock, synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module fac_config_regs_asserts
   import fac_pkg::*;
(
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // register port
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire fac_byte_t reg_addr_in,
   input wire fac_byte_t reg_wdata_in,
   input wire fac_byte_t reg_rdata_out,
   input wire logic reg_rvalid_out,
   // fifo side
   input wire logic readout_last_in,
   input wire logic fifo_wr_out,
   input wire logic fifo_drop_oldest_out,
   input wire logic fifo_frame_lost_out,
   input wire logic sensortime_frame_out,
   // settings outputs
   input wire fac_level_t watermark_out,
   input wire logic [6:0] aux_target_addr_out,
   input wire logic [3:0] aux_burst_bytes_out,
   input wire logic aux_manual_mode_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   logic time_en_r;

   // shadow of the time-enable bit; readout events are judged against it
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) time_en_r <= 1'b1;
      else if (reg_wr_in && reg_addr_in == 8'h48) time_en_r <= reg_wdata_in[1];
   end

   // a write strobe to one offset
   sequence wr_at(a);
      reg_wr_in && reg_addr_in == a;
   endsequence

   function automatic logic [3:0] blen_of(input logic [1:0] c);
      return c == 2'h0 ? 4'h1 : c == 2'h1 ? 4'h2 : c == 2'h2 ? 4'h6 : 4'h8;
   endfunction

   wtm_low_a: assert property (wr_at(8'h46) |-> ##2 watermark_out[7:0] == $past(reg_wdata_in, 2))
      else $error("low watermark byte not applied");
   wtm_high_a: assert property (wr_at(8'h47) |-> ##2 watermark_out[12:8] == $past(reg_wdata_in[4:0], 2))
      else $error("high watermark bits not applied");
   aux_addr_a: assert property (wr_at(8'h4b) |-> ##2 aux_target_addr_out == $past(reg_wdata_in[7:1], 2))
      else $error("aux target address wrong");
   burst_len_a: assert property (wr_at(8'h4c) |-> ##2 aux_burst_bytes_out == blen_of($past(reg_wdata_in[1:0], 2)))
      else $error("burst length decode wrong");
   manual_mode_a: assert property (wr_at(8'h4c) |-> ##2 aux_manual_mode_out == $past(reg_wdata_in[7], 2))
      else $error("manual mode bit wrong");
   rsvd_read_a: assert property (reg_rd_in && reg_addr_in == 8'h47 |=> reg_rvalid_out && reg_rdata_out[7:5] == 3'h0)
      else $error("reserved watermark bits read nonzero");
   unmapped_read_a: assert property (reg_rd_in && reg_addr_in == 8'h4a |=> reg_rvalid_out && reg_rdata_out == 8'h00)
      else $error("unmapped read nonzero");
   rst_values_a: assert property ($fell(rst_in) |=> watermark_out == 13'h200 && aux_burst_bytes_out == 4'h8 && aux_manual_mode_out && aux_target_addr_out == 7'h10)
      else $error("settings outputs not at reset values");
   stamp_frame_a: assert property (readout_last_in && !reg_wr_in |=> sensortime_frame_out == time_en_r)
      else $error("sensortime frame disagrees with enable");
   lost_excl_a: assert property (fifo_frame_lost_out |-> !fifo_wr_out && !fifo_drop_oldest_out)
      else $error("refused frame still written");
   drop_with_wr_a: assert property (fifo_drop_oldest_out |-> fifo_wr_out)
      else $error("eviction without write");
endmodule // fac_config_regs_asserts
bind fac_config_regs fac_config_regs_asserts u_chk (.ref_clk_in, .rst_in, .reg_wr_in, .reg_rd_in,
   .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .reg_rvalid_out, .readout_last_in, .fifo_wr_out,
   .fifo_drop_oldest_out, .fifo_frame_lost_out, .sensortime_frame_out, .watermark_out,
   .aux_target_addr_out, .aux_burst_bytes_out, .aux_manual_mode_out);
`default_nettype wire

// ---- fac_config_regs_bench.sv ----
// fac_config_regs_bench: self-checking bench of the fifo/aux register group.
// assumes: package, interface and design files compiled before this one.
`timescale 1ns/1ps
`default_nettype none
module fac_config_regs_bench
   import fac_pkg::*;
;
   logic ref_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic wr = 1'b0, rd = 1'b0, av = 1'b0, xv = 1'b0, p1 = 1'b0, p2 = 1'b0, full = 1'b0, last = 1'b0;
   fac_byte_t addr = 8'h00, wdat = 8'h00, rdat, hdr;
   fac_axes_t raw = '0, filt = '0, auxd = '0, f_acc, f_aux;
   fac_level_t lvl = '0, wtm;
   logic rv, fw, fd, fl, hh, ap, xp, hit, st, man;
   logic [6:0] tgt;
   logic [3:0] blen;
   int fails = 0, checks_done = 0, n_wr, n_drop, n_lost, n_st, cyc = 0;
   logic [31:0] seed = 32'hac0975cb;
   fac_byte_t sh [68:77];
   localparam fac_byte_t rst_tbl [68:77] = '{8'h00, 8'h80, 8'h00, 8'h02, 8'h02, 8'h10, 8'h00, 8'h20, 8'h83, 8'h00};
   localparam fac_byte_t msk_tbl [68:77] = '{8'h00, 8'hf0, 8'hff, 8'h1f, 8'h03, 8'h7c, 8'h00, 8'hfe, 8'h83, 8'h00};

   fac_config_regs dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_addr_in(addr), .reg_wdata_in(wdat), .reg_rdata_out(rdat), .reg_rvalid_out(rv),
      .acc_valid_in(av), .acc_raw_in(raw), .acc_filt_in(filt), .aux_valid_in(xv),
      .aux_data_in(auxd), .int_pin_one_in(p1), .int_pin_two_in(p2), .fifo_full_in(full),
      .fifo_level_in(lvl), .readout_last_in(last), .fifo_wr_out(fw), .fifo_drop_oldest_out(fd),
      .fifo_frame_lost_out(fl), .frame_has_header_out(hh), .frame_header_out(hdr),
      .frame_acc_present_out(ap), .frame_acc_out(f_acc), .frame_aux_present_out(xp),
      .frame_aux_out(f_aux), .watermark_out(wtm), .watermark_hit_out(hit),
      .sensortime_frame_out(st), .aux_target_addr_out(tgt), .aux_burst_bytes_out(blen),
      .aux_manual_mode_out(man));

   // 50 MHz clock
   initial begin
      forever #10 ref_clk_in = ~ref_clk_in;
   end

   // hang guard; the whole run needs well under a thousand cycles
   always @(posedge ref_clk_in) begin
      cyc++;
      if (cyc == 5000) begin
         fails++;
         results();
      end
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [3:0] blen_of(input logic [1:0] c);
      return c == 2'h0 ? 4'h1 : c == 2'h1 ? 4'h2 : c == 2'h2 ? 4'h6 : 4'h8;
   endfunction
   function automatic fac_byte_t hdr_of(input logic x, input logic a, input logic t1, input logic t2);
      return {3'b100, 1'b0, x, a, t1, t2};
   endfunction

   // inputs move 1 ns after the edge so no race with the design
   task automatic tick();
      @(posedge ref_clk_in);
      #1;
   endtask
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask
   task automatic chk_n(input int got, input int exp);
      chk(48'(got), 48'(exp));
   endtask
   task automatic reg_wr(input fac_byte_t a, input fac_byte_t d);
      wr = 1'b1;
      addr = a;
      wdat = d;
      tick();
      wr = 1'b0;
      if (a >= 8'h44 && a <= 8'h4d) sh[a] = d & msk_tbl[a];
      // idle edge so a following strobe is not raised in this time step
      tick();
   endtask
   task automatic reg_rd(input fac_byte_t a);
      rd = 1'b1;
      addr = a;
      tick();
      rd = 1'b0;
      chk(48'(rv), 48'h1);
      chk(48'(rdat), 48'(sh[a]));
      tick();
   endtask
   // fresh random sample on the chosen sources; watch() ends the strobe
   task automatic send(input logic a, input logic x);
      seed = lfsr(seed);
      raw = {seed, seed[15:0]};
      seed = lfsr(seed);
      filt = {seed[15:0], seed};
      auxd = {raw[23:0], filt[23:0]};
      av = a;
      xv = x;
   endtask
   // counts write-side pulses for n cycles, strobes dropped after feed cycles
   task automatic watch(input int n, input int feed);
      n_wr = 0;
      n_drop = 0;
      n_lost = 0;
      n_st = 0;
      for (int i = 0; i < n; i++) begin
         if (i == feed) {av, xv, last} = 3'b000;
         tick();
         if (fw === 1'b1) n_wr++;
         if (fd === 1'b1) n_drop++;
         if (fl === 1'b1) n_lost++;
         if (st === 1'b1) n_st++;
      end
   endtask
   task automatic results();
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // main sequence
   initial begin
      for (int i = 68; i <= 77; i++) sh[i] = rst_tbl[i];
      repeat (12) tick();
      rst_in = 1'b0;
      for (int a = 68; a <= 77; a++) reg_rd(8'(a));
      for (int a = 68; a <= 77; a++) begin
         seed = lfsr(seed);
         reg_wr(8'(a), seed[7:0]);
         reg_rd(8'(a));
      end
      chk(48'(wtm), 48'({sh[71][4:0], sh[70]}));
      chk(48'(tgt), 48'(sh[75][7:1]));
      for (int c = 0; c < 4; c++) begin
         reg_wr(8'h4c, {c[0], 5'h00, 2'(c)});
         tick();
         chk(48'(blen), 48'(blen_of(2'(c))));
         chk(48'(man), 48'(c[0]));
      end
      lvl = wtm;
      repeat (2) tick();
      chk(48'(hit), 48'h1);
      lvl = wtm - 13'h1;
      repeat (2) tick();
      chk(48'(hit), 48'h0);
      $display("test registers done");
      reg_wr(8'h48, 8'h00);
      reg_wr(8'h45, 8'h80);
      reg_wr(8'h49, 8'h5c);
      {p1, p2} = seed[5:4];
      send(1'b1, 1'b0);
      watch(8, 1);
      chk_n(n_wr, 1);
      chk(f_acc, filt);
      chk(48'(hh), 48'h1);
      chk(48'(hdr), 48'(hdr_of(1'b0, 1'b1, p1, p2)));
      chk(48'(ap), 48'h1);
      chk(48'(xp), 48'h0);
      reg_wr(8'h45, 8'h00);
      send(1'b1, 1'b0);
      watch(8, 1);
      chk(f_acc, raw);
      reg_wr(8'h49, 8'h30);
      send(1'b0, 1'b1);
      watch(8, 1);
      chk(f_aux, auxd);
      chk(48'(hdr), 48'(hdr_of(1'b1, 1'b0, 1'b0, 1'b0)));
      chk(48'(ap), 48'h0);
      chk(48'(xp), 48'h1);
      reg_wr(8'h49, 8'h60);
      send(1'b1, 1'b1);
      watch(8, 1);
      chk(48'(hh), 48'h0);
      chk(48'(ap), 48'h1);
      chk(48'(xp), 48'h1);
      chk(f_aux, auxd);
      reg_wr(8'h49, 8'h00);
      send(1'b1, 1'b1);
      watch(8, 1);
      chk_n(n_wr, 0);
      reg_wr(8'h49, 8'h50);
      full = 1'b1;
      for (int s = 1; s >= 0; s--) begin
         reg_wr(8'h48, 8'(s));
         send(1'b1, 1'b0);
         watch(8, 1);
         chk_n(n_lost, s);
         chk_n(n_wr, 1 - s);
         chk_n(n_drop, 1 - s);
      end
      full = 1'b0;
      $display("test frames done");
      for (int d = 0; d < 4; d++) begin
         reg_wr(8'h45, {1'b1, 3'(d), 4'h0});
         repeat (2) tick();
         av = 1'b1;
         watch(14, 8);
         chk_n(n_wr, 8 >> d);
      end
      $display("test decimation done");
      for (int t = 0; t < 2; t++) begin
         reg_wr(8'h48, {6'h00, 1'(t), 1'b0});
         last = 1'b1;
         watch(4, 1);
         chk_n(n_st, t);
      end
      $display("test readout done");
      results();
   end
endmodule // fac_config_regs_bench
`default_nettype wire
